// ---- pkg/sps_pkg.sv ----
// Constants and types for the stepper phase sequencer.
// Assumes a 200 MHz system clock; all motor inputs arrive asynchronously.
`default_nettype none
package sps_pkg;
  localparam int unsigned SPS_CLK_MHZ = 200;
  localparam int unsigned SPS_RESET_MIN_US = 4;
  localparam int unsigned SPS_RESET_MIN_CYC = SPS_RESET_MIN_US * SPS_CLK_MHZ;
  localparam int unsigned SPS_STEP_MAX_KHZ = 50;
  localparam int unsigned SPS_PULSE_MIN_US = 10;
  localparam int unsigned SPS_PULSE_MIN_CYC = SPS_PULSE_MIN_US * SPS_CLK_MHZ;
  localparam int unsigned SPS_SETUP_US = 4;
  localparam int unsigned SPS_SETUP_CYC = SPS_SETUP_US * SPS_CLK_MHZ;
  // Position index in half steps, 0..7; even = two windings on
  localparam logic [2:0] SPS_POS_RESET = 3'h0;
  localparam logic [2:0] SPS_POS_ONE = 3'h1;
  localparam logic [2:0] SPS_POS_TWO = 3'h2;
  // Phase output order {a, a_bar, b, b_bar}
  localparam logic [3:0] SPS_PHASE_OFF = 4'h0;
  localparam logic [1:0] SPS_SYNC_RESET = 2'h0;

  typedef struct packed {
    logic [1:0] step_sync;
    logic [1:0] dir_sync;
    logic [1:0] mode_sync;
    logic [1:0] en_sync;
    logic [1:0] rst_sync;
    logic step_last;
    logic [2:0] pos;
    logic [3:0] phase;
  } sps_state_s;
endpackage : sps_pkg
`default_nettype wire

// ---- design/sps_sequencer.sv ----
// Stepper phase sequencer: four phase drive outputs from step, direction and mode.
// Assumes the host meets pulse width and setup/hold around step rising edges.
//
// What this block does
// - After reset pattern starts at fixed state, first drive gate on first.
// - Direction and mode sampled and position moves only on step clock rising edge.
// - Direction select level chooses forward or reverse phase order.
// - Enable low forces all four outputs off; high drives pattern.
// - Enable toggling keeps position; steps still move it while disabled, and driving resumes there.
// - Mode low gives two-phase, mode high gives one-two-phase stepping.
// - Reset low clears sequence and cuts all four outputs.
// - After reset, drive A and B-bar windings as initial combination.
// - Mode change keeps position, continues from equivalent phase.
`default_nettype none
module sps_sequencer
  import sps_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic step_clock,
  input wire logic direction_select,
  input wire logic mode_select,
  input wire logic output_enable,
  input wire logic sequence_reset_n,
  output logic phase_a,
  output logic phase_a_bar,
  output logic phase_b,
  output logic phase_b_bar
);

  sps_state_s st_r;
  sps_state_s st_nxt;

  // Synchronised pin levels
  logic step_s;
  logic dir_s;
  logic mode_s;
  logic en_s;
  logic run_s;

  // Step edge and move helpers
  logic rise;
  logic [2:0] stride;
  logic [2:0] pos_step;
  logic [3:0] pattern_now;
  logic [3:0] drive;

  // Two-flop synchroniser shift
  function automatic logic [1:0] sps_sync2(
    input logic [1:0] q,
    input logic d
  );
    logic [1:0] n;

    n = {q[0], d};
    return n;
  endfunction

  // Half-step position to winding pattern {a, a_bar, b, b_bar}
  function automatic logic [3:0] sps_pattern(
    input logic [2:0] pos
  );
    logic [3:0] p;

    p = SPS_PHASE_OFF;
    case (pos)
      3'h0: begin
        p = 4'h9;
      end
      3'h1: begin
        p = 4'h8;
      end
      3'h2: begin
        p = 4'hA;
      end
      3'h3: begin
        p = 4'h2;
      end
      3'h4: begin
        p = 4'h6;
      end
      3'h5: begin
        p = 4'h4;
      end
      3'h6: begin
        p = 4'h5;
      end
      3'h7: begin
        p = 4'h1;
      end
      default: begin
        p = SPS_PHASE_OFF;
      end
    endcase
    return p;
  endfunction

  // Half step in one-two-phase; two-phase lands on the next two-on state
  function automatic logic [2:0] sps_stride(
    input logic half,
    input logic odd
  );
    logic [2:0] s;

    s = SPS_POS_ONE;
    if (half) begin
      s = SPS_POS_ONE;
    end else if (odd) begin
      s = SPS_POS_ONE;
    end else begin
      s = SPS_POS_TWO;
    end
    return s;
  endfunction

  // One move, wrapping over the eight half steps
  function automatic logic [2:0] sps_move(
    input logic [2:0] base,
    input logic [2:0] amount,
    input logic reverse
  );
    logic [2:0] n;

    n = base;
    if (reverse) begin
      n = 3'(base - amount);
    end else begin
      n = 3'(base + amount);
    end
    return n;
  endfunction

  // Enable masks the pattern only
  function automatic logic [3:0] sps_gate(
    input logic [3:0] pattern,
    input logic enable
  );
    logic [3:0] g;

    g = SPS_PHASE_OFF;
    if (enable) begin
      g = pattern;
    end
    return g;
  endfunction

  // Next-state logic
  always_comb begin
    st_nxt = st_r;

    // Second-stage synchroniser outputs
    step_s = st_r.step_sync[1];
    dir_s = st_r.dir_sync[1];
    mode_s = st_r.mode_sync[1];
    en_s = st_r.en_sync[1];
    run_s = st_r.rst_sync[1];

    // Helper defaults
    rise = 1'h0;
    stride = SPS_POS_ONE;
    pos_step = st_r.pos;
    pattern_now = SPS_PHASE_OFF;
    drive = SPS_PHASE_OFF;

    // Every pin passes two flops first
    st_nxt.step_sync = sps_sync2(st_r.step_sync, step_clock);
    st_nxt.dir_sync = sps_sync2(st_r.dir_sync, direction_select);
    st_nxt.mode_sync = sps_sync2(st_r.mode_sync, mode_select);
    st_nxt.en_sync = sps_sync2(st_r.en_sync, output_enable);
    st_nxt.rst_sync = sps_sync2(st_r.rst_sync, sequence_reset_n);

    // Edge detector keeps tracking in sequence reset, so release makes no false step
    st_nxt.step_last = step_s;
    rise = step_s && !st_r.step_last;

    stride = sps_stride(mode_s, st_r.pos[0]);
    pos_step = sps_move(st_r.pos, stride, dir_s);
    pattern_now = sps_pattern(st_r.pos);
    drive = sps_gate(pattern_now, en_s);

    // Position: cleared in sequence reset, moved on each step edge
    if (!run_s) begin
      st_nxt.pos = SPS_POS_RESET;
    end else if (rise) begin
      st_nxt.pos = pos_step;
    end else begin
      st_nxt.pos = st_r.pos;
    end

    // Phases: off in sequence reset, else the gated pattern of the held position
    if (!run_s) begin
      st_nxt.phase = SPS_PHASE_OFF;
    end else begin
      st_nxt.phase = drive;
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the phase register
  assign phase_a = st_r.phase[3];
  assign phase_a_bar = st_r.phase[2];
  assign phase_b = st_r.phase[1];
  assign phase_b_bar = st_r.phase[0];

endmodule // sps_sequencer
`default_nettype wire

// ---- test/sps_checker.sv ----
// Assertions on the phase sequencer pins.
// Assumes step pulses and gaps of at least eight clocks.
`default_nettype none
module sps_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic step_clock,
  input wire logic direction_select,
  input wire logic mode_select,
  input wire logic output_enable,
  input wire logic sequence_reset_n,
  input wire logic phase_a,
  input wire logic phase_a_bar,
  input wire logic phase_b,
  input wire logic phase_b_bar
);
  timeunit 1ns / 1ps;
  logic z;
  wire logic [3:0] p = {phase_a, phase_a_bar, phase_b, phase_b_bar};
  wire logic r = output_enable && sequence_reset_n;
  wire logic [2:0] c = {reset_n, r, step_clock};
  wire logic q = r && !step_clock;
  wire logic g = step_clock && !z && r;
  wire logic h = g && mode_select && p == 4'h9;
  always_ff @(posedge clk) z <= step_clock;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_en_off: assert property (!output_enable [*4] |-> p == 4'h0) else $error("on");
  a_rst_off: assert property (!sequence_reset_n [*4] |-> p == 4'h0) else $error("on");
  a_step_hold: assert property ($stable(c) [*8] |-> $stable(p)) else $error("moved");
  a_init_pat: assert property (!sequence_reset_n ##1 q [*6] |-> p == 4'h9) else $error("init");
  a_two_on: assert property (g && !mode_select |-> ##5 $countones(p) == 2) else $error("two");
  a_half_alt:
    assert property (g && mode_select |-> ##5 $countones(p ^ $past(p, 5)) == 1) else $error("half");
  a_fwd_dir: assert property (h && !direction_select |-> ##5 p == 4'h8) else $error("fwd");
  a_rev_dir: assert property (h && direction_select |-> ##5 p == 4'h1) else $error("rev");
  c_half: cover property (g && mode_select);
  c_two: cover property (g && !mode_select);
  c_off: cover property (!output_enable);
endmodule // sps_checker
bind sps_sequencer sps_checker u_sps_checker (.*);
`default_nettype wire

// ---- test/sps_host.sv ----
// Host controller model: step, direction, mode, enable and sequence reset pins.
// Assumes each task is entered just after a clock edge; pulses shortened to 8 clocks.
`default_nettype none
module sps_host import sps_pkg::*; (
  input wire logic clk,
  output var logic step_clock,
  output var logic direction_select,
  output var logic mode_select,
  output var logic output_enable,
  output var logic sequence_reset_n
);
  timeunit 1ns / 1ps;
  initial begin
    {step_clock, direction_select, mode_select} = 3'h0;
    output_enable = 1'h1;
    sequence_reset_n = 1'h0;
  end
  task automatic step(input logic d, input logic m);
    {direction_select, mode_select} <= {d, m};
    for (int i = 0; i < 3; i++) begin
      repeat (8) @(posedge clk);
      step_clock <= (i == 0);
    end
  endtask
  task automatic seq_reset();
    sequence_reset_n <= 1'h0;
    repeat (SPS_RESET_MIN_CYC) @(posedge clk);
    sequence_reset_n <= 1'h1;
  endtask
  task automatic set_enable(input logic e);
    output_enable <= e;
  endtask
endmodule // sps_host
`default_nettype wire

// ---- test/tb_top.sv ----
// Bench: host calls with the expected phase pattern after each.
// Assumes the host model answers steps in 24 clocks.
`default_nettype none
module tb_top import sps_pkg::*; ;
  timeunit 1ns / 1ps;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [2:0] pos = 3'h0;
  logic [3:0] pat [8] = '{4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1};
  int fail_count = 0, n_compared = 0;
  wire logic step_clock, direction_select, mode_select, output_enable, sequence_reset_n;
  wire logic phase_a, phase_a_bar, phase_b, phase_b_bar;
  wire logic [3:0] ph = {phase_a, phase_a_bar, phase_b, phase_b_bar};
  sps_host u_sps_host (.*);
  sps_sequencer u_sps_sequencer (.*);
  always #2.5 clk = ~clk;
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t: phase %h not %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic d, input logic m, input int n);
    logic [2:0] k;
    repeat (n) begin
      u_sps_host.step(d, m);
      k = (m || pos[0]) ? 3'h1 : 3'h2;
      pos = d ? pos - k : pos + k;
      chk(ph, output_enable ? pat[pos] : 4'h0);
    end
  endtask
  task automatic close_out();
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    u_sps_host.seq_reset();
    repeat (6) @(posedge clk);
    chk(ph, 4'h9);
    go(1'h0, 1'h1, 9);
    go(1'h1, 1'h1, 4);
    go(1'h0, 1'h0, 3);
    $display("stepping test done");
    u_sps_host.set_enable(1'h0);
    repeat (5) @(posedge clk);
    chk(ph, 4'h0);
    go(1'h1, 1'h0, 2);
    u_sps_host.set_enable(1'h1);
    repeat (5) @(posedge clk);
    chk(ph, pat[pos]);
    $display("enable test done");
    u_sps_host.seq_reset();
    pos = 3'h0;
    repeat (6) @(posedge clk);
    chk(ph, 4'h9);
    $display("reset test done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
